// ---- design/comparator_vref_pkg.sv ----
// shared constants and carriers for the comparator and reference control
package comparator_vref_pkg;

   // -------------------------------------------------------------------
   // register map
   // -------------------------------------------------------------------
   localparam int unsigned  REG_ADDR_W      = 12;
   localparam logic [11:0]  CMP_CTRL_OFFSET = 12'h000;
   localparam logic [11:0]  REF_CTRL_OFFSET = 12'h004;

   // -------------------------------------------------------------------
   // comparator control fields
   // -------------------------------------------------------------------
   localparam int unsigned  CMP_A_POS_BIT    = 0;
   localparam int unsigned  CMP_A_NEG_BIT    = 1;
   localparam int unsigned  CMP_B_POS_BIT    = 2;
   localparam int unsigned  CMP_B_NEG_BIT    = 3;
   localparam int unsigned  CMP_A_INV_BIT    = 4;
   localparam int unsigned  CMP_B_INV_BIT    = 5;
   localparam int unsigned  CMP_A_RESULT_BIT = 6;
   localparam int unsigned  CMP_B_RESULT_BIT = 7;
   localparam int unsigned  CMP_CFG_W        = 6;
   localparam logic [5:0]   CMP_CTRL_RESET   = 6'h00;

   // -------------------------------------------------------------------
   // reference control fields
   // -------------------------------------------------------------------
   localparam int unsigned  REF_LEVEL_LSB    = 0;
   localparam int unsigned  REF_LEVEL_W      = 4;
   localparam int unsigned  REF_SOURCE_BIT   = 4;
   localparam int unsigned  REF_RANGE_BIT    = 5;
   localparam int unsigned  REF_PIN_BIT      = 6;
   localparam int unsigned  REF_POWER_BIT    = 7;
   localparam int unsigned  REF_CFG_W        = 8;
   localparam logic [7:0]   REF_CTRL_RESET   = 8'h00;

   // -------------------------------------------------------------------
   // reference level as a fraction of the source span, in 96ths:
   // fine range L/24 = 4L/96, coarse range 1/4 + L/32 = (24 + 3L)/96
   // -------------------------------------------------------------------
   localparam int unsigned  REF_LEVELS       = 16;
   localparam int unsigned  REF_FRAC_W       = 7;
   localparam logic [6:0]   REF_FRAC_DENOM   = 7'h60;
   localparam logic [6:0]   REF_FINE_MULT    = 7'h04;
   localparam logic [6:0]   REF_COARSE_MULT  = 7'h03;
   localparam logic [6:0]   REF_COARSE_BASE  = 7'h18;

   // -------------------------------------------------------------------
   // input synchroniser depth for the analog comparator outputs
   // -------------------------------------------------------------------
   localparam int unsigned  SYNC_STAGES      = 3;

   // -------------------------------------------------------------------
   // carriers
   // -------------------------------------------------------------------
   typedef enum logic [0:0] {
      APB_IDLE   = 1'b0,
      APB_ANSWER = 1'b1
   } apb_phase_t;

   // packed so that bit 0 is aPosSelect, matching the register
   typedef struct packed {
      logic bInvert;
      logic aInvert;
      logic bNegSelect;
      logic bPosSelect;
      logic aNegSelect;
      logic aPosSelect;
   } cmp_cfg_t;

   // packed so that bit 0 is the level lsb, matching the register
   typedef struct packed {
      logic       powerOn;
      logic       pinDrive;
      logic       rangeSelect;
      logic       sourceSelect;
      logic [3:0] level;
   } ref_cfg_t;

   typedef struct packed {
      apb_phase_t  phase;
      logic [31:0] rdata;
      logic        slvErr;
      cmp_cfg_t    cmp;
      ref_cfg_t    vref;
      logic [6:0]  fraction;
   } ctrl_state_t;

   typedef struct packed {
      logic [2:0] sync;
      logic       level;
      logic       result;
   } chan_state_t;

endpackage

// ---- design/comparator_channel.sv ----
// one comparator's result path: synchroniser, agreement filter, inversion
module comparator_channel (
   input  wire logic ref_clk,
   input  wire logic reset_n,
   input  wire logic rawResult,
   input  wire logic invert,
   output logic      level,
   output logic      result
);

   comparator_vref_pkg::chan_state_t state_r;
   comparator_vref_pkg::chan_state_t state_nxt;

   // -------------------------------------------------------------------
   // next state
   // -------------------------------------------------------------------
   // stage 0 is read only by stage 1; a new level counts once stages 1
   // and 2 agree, so a single metastable sample cannot flip the result
   always_comb begin
      state_nxt      = state_r;
      state_nxt.sync = {state_r.sync[1:0], rawResult};
      if (state_r.sync[1] == state_r.sync[2]) begin
         state_nxt.level = state_r.sync[2];
      end
      state_nxt.result = state_r.level ^ invert;
   end

   // state register, cleared on reset
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign level  = state_r.level;
   assign result = state_r.result;

   // -------------------------------------------------------------------
   // checks
   // -------------------------------------------------------------------
   inversion_xor_a: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      ##1 (result == ($past(state_r.level) ^ $past(invert))))
      else $error("channel result is not level xor invert");

   level_filter_a: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      (state_r.sync[2] != state_r.sync[1]) |=> $stable(level))
      else $error("level moved while stages disagreed");

endmodule // comparator_channel

// ---- design/comparator_vref_ctrl.sv ----
// comparator input routing, output inversion and reference control
// behind an APB register slave

// -------------------------------------------------------------------
// module
// -------------------------------------------------------------------
module comparator_vref_ctrl (
   input  wire logic        ref_clk,
   input  wire logic        reset_n,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // analog comparator raw outputs, asynchronous
   input  wire logic        cmpARaw,
   input  wire logic        cmpBRaw,
   // presented comparator results
   output logic             cmpAResult,
   output logic             cmpBResult,
   // analog input multiplexer controls
   output logic             cmpAPosToVinPlus,
   output logic             cmpANegToVinPlus,
   output logic             cmpBPosToVinPlus,
   output logic             cmpBNegToVinPlus,
   // reference ladder controls
   output logic             refPowerOn,
   output logic             refPinDrive,
   output logic             refRangeSelect,
   output logic             refSourceSelect,
   output logic [3:0]       refLevelField,
   output logic [6:0]       refFraction
);

   comparator_vref_pkg::ctrl_state_t state_r;
   comparator_vref_pkg::ctrl_state_t state_nxt;

   logic        levelA;
   logic        levelB;
   logic        hitCmp;
   logic        hitRef;
   logic        accessDone;
   logic [31:0] readWord;

   // -------------------------------------------------------------------
   // comparator result paths
   // -------------------------------------------------------------------
   // each channel registers its own result, so the outputs below come
   // straight from a flip-flop without an extra cycle of delay
   comparator_channel chanA (
      .ref_clk (ref_clk),
      .reset_n (reset_n),
      .rawResult (cmpARaw),
      .invert  (state_r.cmp.aInvert),
      .level   (levelA),
      .result  (cmpAResult)
   );

   comparator_channel chanB (
      .ref_clk (ref_clk),
      .reset_n (reset_n),
      .rawResult (cmpBRaw),
      .invert  (state_r.cmp.bInvert),
      .level   (levelB),
      .result  (cmpBResult)
   );

   // -------------------------------------------------------------------
   // address decode and read data
   // -------------------------------------------------------------------
   // full-address compare: an unaligned or unknown address is unmapped
   always_comb begin
      hitCmp     = (paddr == comparator_vref_pkg::CMP_CTRL_OFFSET);
      hitRef     = (paddr == comparator_vref_pkg::REF_CTRL_OFFSET);
      accessDone = psel && penable && (state_r.phase ==
                   comparator_vref_pkg::APB_ANSWER);
      readWord   = 32'h0000_0000;
      if (hitCmp) begin
         readWord[comparator_vref_pkg::CMP_A_RESULT_BIT] = cmpAResult;
         readWord[comparator_vref_pkg::CMP_B_RESULT_BIT] = cmpBResult;
         readWord[comparator_vref_pkg::CMP_CFG_W-1:0]    = state_r.cmp;
      end else if (hitRef) begin
         readWord[comparator_vref_pkg::REF_CFG_W-1:0]    = state_r.vref;
      end
   end

   // -------------------------------------------------------------------
   // next state
   // -------------------------------------------------------------------
   // one wait state: the access phase answers on its second cycle, which
   // lets read data and the error flag come from flip-flops
   always_comb begin
      state_nxt       = state_r;
      state_nxt.phase = comparator_vref_pkg::APB_IDLE;
      if (psel && penable &&
          (state_r.phase == comparator_vref_pkg::APB_IDLE)) begin
         state_nxt.phase  = comparator_vref_pkg::APB_ANSWER;
         state_nxt.rdata  = pwrite ? 32'h0000_0000 : readWord;
         state_nxt.slvErr = !(hitCmp || hitRef);
      end else begin
         state_nxt.rdata  = 32'h0000_0000;
         state_nxt.slvErr = 1'b0;
      end
      // writes land only on the edge that completes the access
      if (accessDone && pwrite) begin
         if (hitCmp) begin
            // result bits above the config field are read-only
            state_nxt.cmp = comparator_vref_pkg::cmp_cfg_t'(
               pwdata[comparator_vref_pkg::CMP_CFG_W-1:0]);
         end else if (hitRef) begin
            // bits above the low byte are dropped
            state_nxt.vref = comparator_vref_pkg::ref_cfg_t'(
               pwdata[comparator_vref_pkg::REF_CFG_W-1:0]);
         end
      end
      // ladder tap in 96ths of the source span, tracks the register
      if (state_nxt.vref.rangeSelect) begin
         state_nxt.fraction = 7'(comparator_vref_pkg::REF_FINE_MULT *
                              {3'h0, state_nxt.vref.level});
      end else begin
         state_nxt.fraction = 7'(comparator_vref_pkg::REF_COARSE_BASE +
                              comparator_vref_pkg::REF_COARSE_MULT *
                              {3'h0, state_nxt.vref.level});
      end
   end

   // -------------------------------------------------------------------
   // state register
   // -------------------------------------------------------------------
   // everything but the tap fraction clears on reset; the coarse range then taps a quarter
   // of the span, with the ladder powered down
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_r          <= '0;
         state_r.fraction <= comparator_vref_pkg::REF_COARSE_BASE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // -------------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------------
   assign prdata           = state_r.rdata;
   assign pready           = (state_r.phase ==
                              comparator_vref_pkg::APB_ANSWER);
   assign pslverr          = state_r.slvErr;
   assign cmpAPosToVinPlus = state_r.cmp.aPosSelect;
   assign cmpANegToVinPlus = state_r.cmp.aNegSelect;
   assign cmpBPosToVinPlus = state_r.cmp.bPosSelect;
   assign cmpBNegToVinPlus = state_r.cmp.bNegSelect;
   assign refPowerOn       = state_r.vref.powerOn;
   assign refPinDrive      = state_r.vref.pinDrive;
   assign refRangeSelect   = state_r.vref.rangeSelect;
   assign refSourceSelect  = state_r.vref.sourceSelect;
   assign refLevelField    = state_r.vref.level;
   assign refFraction      = state_r.fraction;

   // -------------------------------------------------------------------
   // checks
   // -------------------------------------------------------------------
   sequence cmpWriteDone;
      psel && penable && pready && pwrite && !pslverr &&
      (paddr == comparator_vref_pkg::CMP_CTRL_OFFSET);
   endsequence

   sequence refWriteDone;
      psel && penable && pready && pwrite && !pslverr &&
      (paddr == comparator_vref_pkg::REF_CTRL_OFFSET);
   endsequence

   sequence refReadDone;
      psel && penable && pready && !pwrite &&
      (paddr == comparator_vref_pkg::REF_CTRL_OFFSET);
   endsequence

   invert_b_a: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      ##1 (cmpBResult == ($past(levelB) ^ $past(state_r.cmp.bInvert))))
      else $error("second result does not follow its invert bit");

   invert_a_a: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      ##1 (cmpAResult == ($past(levelA) ^ $past(state_r.cmp.aInvert))))
      else $error("first result does not follow its invert bit");

   mux_select_a: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      cmpWriteDone |=>
         (cmpBNegToVinPlus == $past(pwdata[3])) &&
         (cmpBPosToVinPlus == $past(pwdata[2])) &&
         (cmpANegToVinPlus == $past(pwdata[1])) &&
         (cmpAPosToVinPlus == $past(pwdata[0])))
      else $error("input select outputs differ from written bits");

   pos_hold_a: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      !(psel && penable && pready && pwrite) |=>
         $stable(cmpBPosToVinPlus) && $stable(cmpAPosToVinPlus))
      else $error("positive select moved without a write");

   neg_hold_a: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      refWriteDone |=>
         $stable(cmpANegToVinPlus) && $stable(cmpBNegToVinPlus))
      else $error("negative select moved on a reference write");

   pos_select_a: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      cmpWriteDone |=> ##1 (cmpAPosToVinPlus == $past(pwdata[0], 2)))
      else $error("first positive select lost its written value");

   range_bit_a: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      refWriteDone |=> (refRangeSelect == $past(pwdata[5])))
      else $error("range select differs from bit five");

   source_bit_a: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      refWriteDone |=> (refSourceSelect == $past(pwdata[4])))
      else $error("source select differs from bit four");

   power_pin_a: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      refWriteDone |=> (refPowerOn == $past(pwdata[7])) &&
                       (refPinDrive == $past(pwdata[6])))
      else $error("power or pin drive differs from written bits");

   pin_drive_a: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      cmpWriteDone |=> $stable(refPinDrive))
      else $error("pin drive moved on a comparator write");

   ladder_tap_a: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      refWriteDone |=> (refFraction == ($past(pwdata[5]) ?
         7'(4 * $past(pwdata[3:0])) : 7'(24 + 3 * $past(pwdata[3:0])))))
      else $error("ladder tap fraction is wrong");

   ladder_span_a: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      refRangeSelect ? (refFraction <= 7'h3c)
                     : (refFraction >= 7'h18 && refFraction <= 7'h45))
      else $error("ladder tap outside its range");

   upper_zero_a: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      refReadDone |-> (prdata[31:8] == 24'h00_0000))
      else $error("unimplemented reference bits read nonzero");

   one_wait_a: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      (psel && !penable) ##1 (psel && penable) |-> !pready ##1 pready)
      else $error("apb answer not on second access cycle");

   sequence cmpReadDone;
      psel && penable && pready && !pwrite &&
      (paddr == comparator_vref_pkg::CMP_CTRL_OFFSET);
   endsequence

   sequence badAccessDone;
      psel && penable && pready &&
      (paddr != comparator_vref_pkg::CMP_CTRL_OFFSET) &&
      (paddr != comparator_vref_pkg::REF_CTRL_OFFSET);
   endsequence

   cmp_read_a: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      cmpReadDone |-> (prdata[31:8] == 24'h00_0000) &&
         (prdata[3:0] == {cmpBNegToVinPlus, cmpBPosToVinPlus,
                          cmpANegToVinPlus, cmpAPosToVinPlus}))
      else $error("comparator register read is wrong");

   bad_error_a: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      badAccessDone |-> pslverr && (prdata == 32'h0000_0000))
      else $error("unmapped access did not answer with an error");

   bad_write_a: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      badAccessDone |=> $stable(refFraction) && $stable(refLevelField) &&
         $stable(cmpAPosToVinPlus) && $stable(cmpBNegToVinPlus))
      else $error("unmapped write changed a setting");

   ready_pulse_a: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      pready |=> !pready)
      else $error("pready stood longer than one cycle");

   idle_quiet_a: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      !pready |-> !pslverr && (prdata == 32'h0000_0000))
      else $error("error or read data outside the answer cycle");

   level_field_a: assert property (
      @(posedge ref_clk) disable iff (!reset_n)
      refWriteDone |=> (refLevelField == $past(pwdata[3:0])))
      else $error("level field differs from written bits");

endmodule // comparator_vref_ctrl

// ---- verification/analog_comparator_model.sv ----
// behavioural model of the two analog comparators and the reference ladder
module analog_comparator_model (
   input  wire logic       cmpAPosToVinPlus,
   input  wire logic       cmpANegToVinPlus,
   input  wire logic       cmpBPosToVinPlus,
   input  wire logic       cmpBNegToVinPlus,
   input  wire logic       refPowerOn,
   input  wire logic [6:0] refFraction,
   input  wire logic [6:0] vinPlusA,
   input  wire logic [6:0] vinMinusA,
   input  wire logic [6:0] vinPlusB,
   input  wire logic [6:0] vinMinusB,
   output logic            cmpARaw,
   output logic            cmpBRaw
);
   timeunit 1ns;
   timeprecision 1ps;

   // ---------------------------------------------------------------
   // analog levels, all in 96ths of the source span
   // ---------------------------------------------------------------
   logic [6:0] vrefLevel;
   logic [6:0] posA;
   logic [6:0] negA;
   logic [6:0] posB;
   logic [6:0] negB;

   // a powered-down ladder sits at ground, so routing to it reads zero
   assign vrefLevel = refPowerOn ? refFraction : 7'h00;
   // each input mux picks the VIN+ source when its select is high
   assign posA = cmpAPosToVinPlus ? vinPlusA : vrefLevel;
   assign negA = cmpANegToVinPlus ? vinPlusA : vinMinusA;
   assign posB = cmpBPosToVinPlus ? vinPlusB : vrefLevel;
   assign negB = cmpBNegToVinPlus ? vinPlusB : vinMinusB;
   // equal levels resolve low: no hysteresis margin is modelled
   // results reach the bench directly; pad drive is not modelled, so no
   // remappable pin is owed a mapping
   assign cmpARaw = posA > negA;
   assign cmpBRaw = posB > negB;
endmodule // analog_comparator_model

// ---- verification/tb_comparator_vref_ctrl.sv ----
// self-checking testbench for the comparator and reference control block
module tb_comparator_vref_ctrl;
   timeunit 1ns;
   timeprecision 1ps;

   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   logic        ref_clk, reset_n, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdData;
   logic        cmpARaw, cmpBRaw, cmpAResult, cmpBResult, rdErr;
   logic        cmpAPosToVinPlus, cmpANegToVinPlus;
   logic        cmpBPosToVinPlus, cmpBNegToVinPlus;
   logic        refPowerOn, refPinDrive, refRangeSelect, refSourceSelect;
   logic [3:0]  refLevelField;
   logic [6:0]  refFraction, vinPlusA, vinMinusA, vinPlusB, vinMinusB;
   logic [31:0] word, rnd;
   logic [5:0]  cfg;
   logic        resA, resB;
   int          seed, numErrors, cmpCount, cycles;

   comparator_vref_ctrl DUT (.ref_clk, .reset_n, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .cmpARaw, .cmpBRaw,
      .cmpAResult, .cmpBResult, .cmpAPosToVinPlus, .cmpANegToVinPlus,
      .cmpBPosToVinPlus, .cmpBNegToVinPlus, .refPowerOn, .refPinDrive,
      .refRangeSelect, .refSourceSelect, .refLevelField, .refFraction);

   analog_comparator_model analog (.cmpAPosToVinPlus, .cmpANegToVinPlus,
      .cmpBPosToVinPlus, .cmpBNegToVinPlus, .refPowerOn, .refFraction,
      .vinPlusA, .vinMinusA, .vinPlusB, .vinMinusB, .cmpARaw, .cmpBRaw);

   // ---------------------------------------------------------------
   // clock and hang guard
   // ---------------------------------------------------------------
   initial ref_clk = 1'b0;
   always #2 ref_clk = ~ref_clk;
   // the whole run needs about 700 cycles; this leaves ample margin
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         numErrors++;
         finishTest();
      end
   end

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic finishTest();
      $display("comparisons %0d mismatches %0d", cmpCount, numErrors);
      if (numErrors == 0 && cmpCount > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic checkData(input string what, input logic [31:0] exp,
                            input logic [31:0] got);
      cmpCount++;
      if (got !== exp) begin
         numErrors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic checkFlag(input string what, input logic exp,
                            input logic got);
      cmpCount++;
      if (got !== exp) begin
         numErrors++;
         $display("ERROR %s expected %b seen %b", what, exp, got);
      end
   endtask

   // one apb transfer; request held until pready is seen at an edge
   task automatic apb(input logic wr, input logic [11:0] addr,
                      input logic [31:0] wdata);
      @(posedge ref_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= addr;
      pwdata  <= wdata;
      @(posedge ref_clk);
      penable <= 1'b1;
      // no cycle count is assumed: only the hang guard ends this wait
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      rdData = prdata;
      rdErr  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdCheck(input string what, input logic [11:0] addr,
                          input logic [31:0] exp, input logic expErr);
      apb(1'b0, addr, 32'h0000_0000);
      checkData(what, exp, rdData);
      checkFlag("pslverr", expErr, rdErr);
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   task automatic applyReset();
      @(posedge ref_clk);
      reset_n <= 1'b0;
      repeat (5) @(posedge ref_clk);
      reset_n <= 1'b1;
      settle(1);
   endtask

   function automatic logic [6:0] expFrac(input logic fine,
                                          input logic [3:0] lvl);
      return fine ? 7'(4 * lvl) : 7'(24 + 3 * lvl);
   endfunction

   function automatic logic expRaw(input logic ps, input logic ns,
      input logic [6:0] vp, input logic [6:0] vm, input logic [6:0] vr);
      logic [6:0] p;
      logic [6:0] q;
      p = ps ? vp : vr;
      q = ns ? vp : vm;
      return p > q;
   endfunction

   function automatic logic [6:0] rnd7();
      return 7'(($random(seed) & 32'h0000_007F) % 96);
   endfunction

   function automatic logic [31:0] refPorts();
      return {17'h0_0000, refFraction, refLevelField, refSourceSelect,
              refRangeSelect, refPinDrive, refPowerOn};
   endfunction

   function automatic logic [31:0] cmpPorts();
      return {26'h000_0000, cmpBResult, cmpAResult, cmpBNegToVinPlus,
              cmpBPosToVinPlus, cmpANegToVinPlus, cmpAPosToVinPlus};
   endfunction

   // reset state: everything clear, ladder tap at a quarter span
   task automatic checkResetState(input string name);
      checkData("ref ports", 32'h0000_1800, refPorts());
      checkData("cmp ports", 32'h0000_0000, cmpPorts());
      rdCheck("ref reg", 12'h004, 32'h0000_0000, 1'b0);
      rdCheck("cmp reg", 12'h000, 32'h0000_0000, 1'b0);
      $display("test %s done", name);
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      seed = 32'h365f_9df9;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {vinPlusA, vinPlusB, vinMinusA, vinMinusB} = '0;
      reset_n = 1'b0;
      applyReset();
      checkResetState("reset");
      // unmapped places answer with an error, read zero, change nothing
      apb(1'b1, 12'h008, 32'hFFFF_FFFF);
      checkFlag("pslverr", 1'b1, rdErr);
      rdCheck("unmapped", 12'h008, 32'h0000_0000, 1'b1);
      rdCheck("unmapped", 12'h00C, 32'h0000_0000, 1'b1);
      rdCheck("ref reg", 12'h004, 32'h0000_0000, 1'b0);
      rdCheck("cmp reg", 12'h000, 32'h0000_0000, 1'b0);
      $display("test %s done", "unmapped");
      // every level of both ranges, other bits and upper junk at random
      for (int i = 0; i < 32; i++) begin
         rnd  = $random(seed);
         word = {rnd[31:6], i[4], rnd[4], i[3:0]};
         apb(1'b1, 12'h004, word);
         settle(2);
         checkFlag("power", word[7], refPowerOn);
         checkFlag("pin", word[6], refPinDrive);
         checkFlag("range", word[5], refRangeSelect);
         checkFlag("source", word[4], refSourceSelect);
         checkData("level", {28'h000_0000, word[3:0]},
                   {28'h000_0000, refLevelField});
         checkData("tap", {25'h000_0000, expFrac(word[5], word[3:0])},
                   {25'h000_0000, refFraction});
         rdCheck("ref reg", 12'h004, {24'h00_0000, word[7:0]}, 1'b0);
      end
      $display("test %s done", "reference");
      // routing and inversion against the analog model
      for (int i = 0; i < 16; i++) begin
         rnd = $random(seed);
         cfg = (i == 0) ? 6'h3F : (i == 1) ? 6'h00 : rnd[5:0];
         @(posedge ref_clk);
         vinPlusA  <= rnd7();
         vinMinusA <= rnd7();
         vinPlusB  <= rnd7();
         vinMinusB <= rnd7();
         word = $random(seed);
         apb(1'b1, 12'h004, word);
         apb(1'b1, 12'h000, {rnd[31:6], cfg});
         // results need the synchroniser and ladder to settle first
         settle(8);
         // expected tap from the written word; powered down reads ground
         rnd = {25'h000_0000, word[7] ? expFrac(word[5], word[3:0]) : 7'h00};
         resA = expRaw(cfg[0], cfg[1], vinPlusA, vinMinusA, rnd[6:0]) ^ cfg[4];
         resB = expRaw(cfg[2], cfg[3], vinPlusB, vinMinusB, rnd[6:0]) ^ cfg[5];
         word = {26'h000_0000, resB, resA, cfg[3:0]};
         checkData("routing", word, cmpPorts());
         checkFlag("result a", resA, cmpAResult);
         checkFlag("result b", resB, cmpBResult);
         rdCheck("cmp reg", 12'h000, {24'h00_0000, resB, resA, cfg},
                 1'b0);
      end
      $display("test %s done", "comparators");
      // a second reset in mid-run clears every setting again
      applyReset();
      checkResetState("second reset");
      finishTest();
   end
endmodule // tb_comparator_vref_ctrl
